// >>> logic/wdt_params.svh
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
// register byte addresses
`define ADDR_CTRL 4'h0
`define ADDR_STAT 4'h4
`define ADDR_MASK 4'h8
`define ADDR_CLKD 4'hc
// control register fields
`define CTL_EN 0
`define CTL_IE 1
`define CTL_RESTART 2
`define CTL_SEL_LO 4
`define CTL_SRCF 8
// status / mask fields
`define ST_WARN 0
`define ST_RST 1
// clock divide field, then timer constants
`define CLKD_SLOW 2
`define SLOW_LIMIT 8'hff
`define WARN_LEAD 22'h000200
`define RESET_VECTOR 16'h8000
`define RST_PULSE 4'h8
`define SHIFT_BASE 5'h0c
`define SHIFT_STEP 5'h03
`endif

// >>> logic/wdt_pkg.sv
package wdt_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_WARN = 3'b010,
        ST_RST = 3'b100
    } wdt_state_t;
endpackage

// >>> logic/divided_system_clock_divider.sv
`timescale 1ns/1ps
`include "wdt_params.svh"
module sys_tick_divider (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // mode
    input wire logic [1:0] div_sel,
    input wire logic slow_en,
    // enable out
    output logic tick
);
    logic [7:0] cnt_q;
    logic [7:0] limit;

    always_comb begin
        if (slow_en) begin
            limit = `SLOW_LIMIT;
        end else begin
            limit = 8'(({7'h0, 1'b1} << div_sel) - 8'h01);
        end
    end

    // one system clock per 1/2/4/8 or 256 oscillator cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule

// >>> logic/watchdog_reset_timer.sv
`timescale 1ns/1ps
`include "wdt_params.svh"
module watchdog_reset_timer (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // axi4-lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // system
    output logic irq,
    output logic sys_reset,
    output logic [15:0] restart_pc
);
    logic en_q, ie_q, srcf_q;
    logic [1:0] sel_q;
    logic [1:0] mask_q, stat_q;
    logic [1:0] div_q;
    logic slow_q;
    logic [21:0] cnt_q;
    logic [3:0] rst_cnt_q;
    wdt_pkg::wdt_state_t state_q;
    logic tick;
    logic [3:0] aw_addr_q;
    logic aw_have_q, w_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic restart;
    logic [21:0] timeout;
    logic warn_ev, rst_ev;

    function automatic logic [21:0] period(input logic [1:0] sel);
        logic [4:0] sh;
        sh = 5'(`SHIFT_BASE + 5'(`SHIFT_STEP * {3'h0, sel}));
        period = 22'((23'h1 << sh) - 23'h1);
    endfunction

    sys_tick_divider u_div (
        .clock(clock),
        .rst_n(rst_n),
        .div_sel(div_q),
        .slow_en(slow_q),
        .tick(tick)
    );

    // write channel: address and data taken in either order
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control, mask and clock divide register fields
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
            ie_q <= 1'b0;
            sel_q <= 2'h0;
            mask_q <= 2'h0;
            div_q <= 2'h0;
            slow_q <= 1'b0;
        end else if (wr_fire && wstrb_q[0]) begin
            case (aw_addr_q)
                `ADDR_CTRL: begin
                    en_q <= wdata_q[`CTL_EN];
                    ie_q <= wdata_q[`CTL_IE];
                    sel_q <= wdata_q[`CTL_SEL_LO +: 2];
                end
                `ADDR_MASK: mask_q <= wdata_q[1:0];
                `ADDR_CLKD: begin
                    div_q <= wdata_q[1:0];
                    slow_q <= wdata_q[`CLKD_SLOW];
                end
                default: ;
            endcase
        end
    end

    assign restart = wr_fire && wstrb_q[0] && aw_addr_q == `ADDR_CTRL
        && wdata_q[`CTL_RESTART];
    assign timeout = period(sel_q);

    // count of system clock ticks, cleared on restart or while disabled in the run state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 22'h0;
            state_q <= wdt_pkg::ST_RUN;
            rst_cnt_q <= 4'h0;
            sys_reset <= 1'b0;
            restart_pc <= `RESET_VECTOR;
        end else begin
            case (state_q)
                wdt_pkg::ST_RUN: begin
                    sys_reset <= 1'b0;
                    if (restart || !en_q) begin
                        cnt_q <= 22'h0;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 22'h1;
                        if (cnt_q + 22'h1 == timeout - `WARN_LEAD + 22'h1) begin
                            state_q <= wdt_pkg::ST_WARN;
                        end
                    end
                end
                wdt_pkg::ST_WARN: begin
                    if (restart) begin
                        cnt_q <= 22'h0;
                        state_q <= wdt_pkg::ST_RUN;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 22'h1;
                        if (cnt_q == timeout) begin
                            state_q <= wdt_pkg::ST_RST;
                            sys_reset <= 1'b1;
                            rst_cnt_q <= `RST_PULSE;
                        end
                    end
                end
                wdt_pkg::ST_RST: begin
                    cnt_q <= 22'h0;
                    restart_pc <= `RESET_VECTOR;
                    if (rst_cnt_q == 4'h1) begin
                        sys_reset <= 1'b0;
                        state_q <= wdt_pkg::ST_RUN;
                    end
                    rst_cnt_q <= rst_cnt_q - 4'h1;
                end
                default: state_q <= wdt_pkg::ST_RUN;
            endcase
        end
    end

    assign warn_ev = state_q == wdt_pkg::ST_RUN && tick && !restart && en_q
        && (cnt_q + 22'h1 == timeout - `WARN_LEAD + 22'h1);
    assign rst_ev = state_q == wdt_pkg::ST_WARN && tick && !restart && cnt_q == timeout;

    // sticky status, write one clears, set wins; warning gated by ie
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= 2'h0;
            srcf_q <= 1'b0;
        end else begin
            if (wr_fire && wstrb_q[0] && aw_addr_q == `ADDR_STAT) begin
                stat_q <= stat_q & ~wdata_q[1:0];
            end
            if (wr_fire && wstrb_q[1] && aw_addr_q == `ADDR_CTRL && wdata_q[`CTL_SRCF]) begin
                srcf_q <= 1'b0;
            end
            if (warn_ev && ie_q) begin
                stat_q[`ST_WARN] <= 1'b1;
            end
            if (rst_ev) begin
                stat_q[`ST_RST] <= 1'b1;
                srcf_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

    // read channel, arready one cycle and rvalid two cycles from arvalid
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `ADDR_CTRL: s_axi_rdata <= {23'h0, srcf_q, 2'h0, sel_q,
                        1'b0, 1'b0, ie_q, en_q};
                    `ADDR_STAT: s_axi_rdata <= {30'h0, stat_q};
                    `ADDR_MASK: s_axi_rdata <= {30'h0, mask_q};
                    `ADDR_CLKD: s_axi_rdata <= {29'h0, slow_q, div_q};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    warn_lead_a: assert property (@(posedge clock) disable iff (!rst_n)
        warn_ev |-> timeout - cnt_q == `WARN_LEAD) else $error("warning not 512 ahead");
    reset_fire_a: assert property (@(posedge clock) disable iff (!rst_n)
        rst_ev |=> sys_reset && srcf_q) else $error("timeout without reset");
    restart_clr_a: assert property (@(posedge clock) disable iff (!rst_n)
        restart && state_q != wdt_pkg::ST_RST |=> cnt_q == 22'h0) else $error("restart ignored");
    vector_a: assert property (@(posedge clock) disable iff (!rst_n)
        sys_reset |-> restart_pc == `RESET_VECTOR) else $error("bad vector");
    tick_only_a: assert property (@(posedge clock) disable iff (!rst_n)
        !tick && state_q == wdt_pkg::ST_RUN && !restart |=> cnt_q == $past(cnt_q)
        || cnt_q == 22'h0) else $error("count moved without tick");
    irq_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        |(stat_q & mask_q) |=> irq) else $error("irq missing");
    warn_cv: cover property (@(posedge clock) disable iff (!rst_n) warn_ev);
    rst_cv: cover property (@(posedge clock) disable iff (!rst_n) rst_ev);
    kick_cv: cover property (@(posedge clock) disable iff (!rst_n)
        restart && state_q == wdt_pkg::ST_WARN);
endmodule

// >>> tb/test_watchdog_reset_timer.sv
`timescale 1ns/1ps
module test_watchdog_reset_timer;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] wstrb = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, sys_reset;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    logic [1:0] rs;
    logic [15:0] restart_pc;
    int err_count = 0;
    int cmp_count = 0;

    always #4 clock = ~clock;

    watchdog_reset_timer i_dut (.clock(clock), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
        .sys_reset(sys_reset), .restart_pc(restart_pc));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        // one edge between transfers so no request line is driven twice in a step
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clock);
            if (awready === 1'b1 && !aw) begin
                awvalid <= 1'b0;
                aw = 1'b1;
            end
            if (wready === 1'b1 && !w) begin
                wvalid <= 1'b0;
                w = 1'b1;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
        rs = bresp;
    endtask

    task automatic rdw(input logic [3:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask

    task automatic reset_values();
        for (int i = 0; i < 4; i++) begin
            rdw(4'(4 * i));
            chk(rd, 32'h0);
        end
        chk({16'h0, restart_pc}, 32'h8000);
        chk({31'h0, sys_reset}, 32'h0);
        rdw(4'h1);
        chk({30'h0, rs}, 32'h2);
        chk(rd, 32'h0);
        wr(4'h2, 32'h1, 4'hf);
        chk({30'h0, rs}, 32'h2);
        $display("test reset_values done");
    endtask

    task automatic keep_alive();
        logic bad;
        bad = 1'b0;
        wr(4'hc, 32'h0, 4'hf);
        wr(4'h8, 32'h3, 4'hf);
        wr(4'h0, 32'h3, 4'hf);
        repeat (4) begin
            repeat (3000) begin
                @(posedge clock);
                if (sys_reset !== 1'b0 || irq !== 1'b0) bad = 1'b1;
            end
            wr(4'h0, 32'h7, 4'hf);
        end
        chk({31'h0, bad}, 32'h0);
        rdw(4'h0);
        chk(rd, 32'h3);
        wr(4'h0, 32'h0, 4'hf);
        $display("test keep_alive done");
    endtask

    // 4096 system clocks at select 0; divide field stretches each one
    task automatic timeout(input logic [31:0] div);
        int n, m, h, e;
        n = 0;
        m = 0;
        h = 0;
        e = 512 * (div + 1);
        wr(4'hc, div, 4'hf);
        wr(4'h8, 32'h1, 4'hf);
        wr(4'h0, 32'h3, 4'hf);
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        while (sys_reset !== 1'b1 && m < 5000) begin
            @(posedge clock);
            m++;
        end
        while (sys_reset === 1'b1 && h < 20) begin
            @(posedge clock);
            h++;
        end
        // two cycles of slack for the registered irq and reset outputs
        chk({31'h0, m + 2 >= e && m <= e + 2}, 32'h1);
        chk({31'h0, n + m + 16 >= 8 * e && n + m <= 8 * e + 16}, 32'h1);
        chk(h, 32'h8);
        chk({16'h0, restart_pc}, 32'h8000);
        rdw(4'h0);
        chk(rd & 32'h100, 32'h100);
        rdw(4'h4);
        chk(rd, 32'h3);
        wr(4'h8, 32'h0, 4'hf);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(4'h8, 32'h3, 4'hf);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        wr(4'h0, 32'h100, 4'h3);
        wr(4'h4, 32'h3, 4'hf);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        rdw(4'h0);
        chk(rd, 32'h0);
        $display("test timeout done");
    endtask

    // ten slow ticks counted first, then fast: a wrong slow rate moves the warning
    task automatic power_mode();
        int n;
        n = 0;
        wr(4'hc, 32'h4, 4'hf);
        wr(4'h8, 32'h1, 4'hf);
        wr(4'h0, 32'h3, 4'hf);
        repeat (2560) @(posedge clock);
        wr(4'hc, 32'h0, 4'hf);
        while (irq !== 1'b1 && n < 5000) begin
            @(posedge clock);
            n++;
        end
        // warning at 4096 - 512 ticks, ten already spent in slow mode
        chk({31'h0, n + 10 + 8 >= 3584 && n + 10 <= 3584 + 8}, 32'h1);
        rdw(4'hc);
        chk(rd, 32'h0);
        wr(4'h0, 32'h0, 4'hf);
        wr(4'h4, 32'h3, 4'hf);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        $display("test power_mode done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        reset_values();
        keep_alive();
        timeout(32'h0);
        timeout(32'h1);
        power_mode();
        tally_and_finish();
    end

    // tests need about 31000 cycles
    initial begin
        repeat (60000) @(posedge clock);
        err_count++;
        tally_and_finish();
    end
endmodule
